// ===== rsd_display.sv
// Purpose: receiver status display driver for a one-digit seven-segment display
// Assumes: status inputs come from logic on mclk; mode pins are straps, synchronised here
// Notes: long counts are parameters so simulation can shorten them
// Contract
// - power-on shows eight, then t and response
// - normal operation shows selected mode digit
// - weak signal flashes the mode digit
// - error class letters F, E, U
// - letter then code, repeated while error
// - blocking error latched until power-up
// - enter alignment if unaligned or 5 s interrupted
// - uniform: top, middle, bottom thirds
// - mixed: top res 2, bottom res 1
// - segment on all, flash some, off none
// - leave alignment after 5 s free
`timescale 1ns/10ps
`default_nettype none
module rsd_display #(
	parameter int SELFTEST_CYC = rsd_pkg::SELFTEST_CYC,
	parameter int RESP_CYC = rsd_pkg::RESP_CYC,
	parameter int ERRPH_CYC = rsd_pkg::ERRPH_CYC,
	parameter int ALIGN_CYC = rsd_pkg::ALIGN_CYC,
	parameter int FLASH_HALF_CYC = rsd_pkg::FLASH_HALF_CYC
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// configuration straps (pins)
	input wire logic [3:0] modeSel,
	input wire logic mixedRes,
	// receiver core status
	input wire logic [7:0] respTimeBcd,
	input wire logic weakSignal,
	input wire logic aligned,
	input wire logic fieldFree,
	input wire rsd_pkg::rsd_beams_t beams,
	input wire rsd_pkg::rsd_err_t err,
	// display
	output logic [6:0] segments,
	output logic alignView
);
	// ************************************************************
	// state
	// ************************************************************
	typedef enum logic [4:0] {
		ST_SELFTEST = 5'h01,
		ST_RESP_T = 5'h02,
		ST_RESP_NUM = 5'h04,
		ST_RUN = 5'h08,
		ST_ALIGN = 5'h10
	} rsd_state_t;

	localparam int TW = $clog2(ALIGN_CYC + 1);
	localparam int FW = $clog2(FLASH_HALF_CYC + 1);

	rsd_state_t state;
	logic [TW-1:0] phaseCnt;
	logic [TW-1:0] fieldCnt;
	logic [FW-1:0] flashCnt;
	logic flashOn;
	logic [3:0] modeMeta;
	logic [3:0] mode;
	logic mixedMeta;
	logic mixed;
	logic blockLatch;
	rsd_pkg::rsd_err_t heldErr;
	logic errShowCode;
	logic [TW-1:0] errCnt;
	logic respDigit;
	logic errActive;
	logic [3:0] digitVal;
	logic [6:0] digitGlyph;
	logic [6:0] next_segments;
	logic [6:0] alignSegs;
	logic [6:0] letter;
	logic enterAlign;
	logic leaveAlign;

	// ************************************************************
	// strap synchroniser and flash timebase
	// ************************************************************
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			modeMeta <= 4'h0;
			mode <= 4'h0;
			mixedMeta <= 1'b0;
			mixed <= 1'b0;
		end else begin
			modeMeta <= modeSel;
			mode <= modeMeta;
			mixedMeta <= mixedRes;
			mixed <= mixedMeta;
		end
	end

	// one enable-driven toggle serves all flashing so everything blinks in phase
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			flashCnt <= '0;
			flashOn <= 1'b1;
		end else if (flashCnt == FW'(FLASH_HALF_CYC - 1)) begin
			flashCnt <= '0;
			flashOn <= !flashOn;
		end else begin
			flashCnt <= flashCnt + FW'(1);
		end
	end

	// ************************************************************
	// error capture
	// ************************************************************
	// blocking error sticks; only a reset (power-up) releases it
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			blockLatch <= 1'b0;
			heldErr <= '0;
		end else if (!blockLatch && err.pending) begin
			blockLatch <= err.blocking;
			heldErr <= err;
		end else if (!blockLatch) begin
			heldErr <= '0;
		end
	end

	assign errActive = heldErr.pending || blockLatch;

	// letter phase then code phase, cycling
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			errCnt <= '0;
			errShowCode <= 1'b0;
		end else if (!errActive) begin
			errCnt <= '0;
			errShowCode <= 1'b0;
		end else if (errCnt == TW'(ERRPH_CYC - 1)) begin
			errCnt <= '0;
			errShowCode <= !errShowCode;
		end else begin
			errCnt <= errCnt + TW'(1);
		end
	end

	// ************************************************************
	// sequencing
	// ************************************************************
	// field timer counts how long the field has been interrupted in run, or free in alignment
	// cleared on every view change: a count saturated before run must not block or skip a switch
	assign enterAlign = (state == ST_RUN) && (!aligned || (fieldCnt >= TW'(ALIGN_CYC - 1)));
	assign leaveAlign = (state == ST_ALIGN) && aligned && (fieldCnt >= TW'(ALIGN_CYC - 1));

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			fieldCnt <= '0;
		end else if (enterAlign || leaveAlign || (state != ST_RUN && state != ST_ALIGN)) begin
			fieldCnt <= '0;
		end else if ((state == ST_RUN && fieldFree) || (state == ST_ALIGN && !fieldFree)) begin
			fieldCnt <= '0;
		end else if (fieldCnt != TW'(ALIGN_CYC)) begin
			fieldCnt <= fieldCnt + TW'(1);
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state <= ST_SELFTEST;
			phaseCnt <= '0;
		end else begin
			case (state)
				ST_SELFTEST: begin
					phaseCnt <= phaseCnt + TW'(1);
					if (phaseCnt == TW'(SELFTEST_CYC - 1)) begin
						phaseCnt <= '0;
						state <= ST_RESP_T;
					end
				end
				ST_RESP_T: begin
					phaseCnt <= phaseCnt + TW'(1);
					if (phaseCnt == TW'(RESP_CYC - 1)) begin
						phaseCnt <= '0;
						state <= ST_RESP_NUM;
					end
				end
				ST_RESP_NUM: begin
					phaseCnt <= phaseCnt + TW'(1);
					if (phaseCnt == TW'(2 * RESP_CYC - 1)) begin
						phaseCnt <= '0;
						state <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (enterAlign) begin
						state <= ST_ALIGN;
					end
				end
				ST_ALIGN: begin
					if (leaveAlign) begin
						state <= ST_RUN;
					end
				end
				default: state <= ST_SELFTEST;
			endcase
		end
	end

	// ************************************************************
	// glyph selection
	// ************************************************************
	assign respDigit = (phaseCnt < TW'(RESP_CYC)) ? 1'b1 : 1'b0;

	always_comb begin
		case (heldErr.errClass)
			rsd_pkg::CLASS_INTERNAL: letter = rsd_pkg::GLYPH_F;
			rsd_pkg::CLASS_EXTERNAL: letter = rsd_pkg::GLYPH_E;
			default: letter = rsd_pkg::GLYPH_U;
		endcase
	end

	always_comb begin
		digitVal = mode;
		if (errActive) begin
			digitVal = heldErr.code;
		end else if (state == ST_RESP_NUM) begin
			digitVal = respDigit ? respTimeBcd[7:4] : respTimeBcd[3:0];
		end
	end

	rsd_digit digitRom (
		.value(digitVal),
		.glyph(digitGlyph)
	);

	// each zone (middle forced dark when mixed): lit when all clear, flashing when some, dark when none
	always_comb begin
		alignSegs = rsd_pkg::GLYPH_BLANK;
		for (int i = 0; i < 3; i++) begin
			logic lit;
			lit = beams.allClear[i] || (beams.anyClear[i] && flashOn);
			case (i)
				0: alignSegs[rsd_pkg::SEG_TOP] = lit;
				1: alignSegs[rsd_pkg::SEG_MID] = lit && !mixed;
				default: alignSegs[rsd_pkg::SEG_BOT] = lit;
			endcase
		end
	end

	always_comb begin
		next_segments = rsd_pkg::GLYPH_BLANK;
		if (errActive) begin
			next_segments = errShowCode ? digitGlyph : letter;
		end else begin
			case (state)
				ST_SELFTEST: next_segments = rsd_pkg::GLYPH_EIGHT;
				ST_RESP_T: next_segments = rsd_pkg::GLYPH_T;
				ST_RESP_NUM: next_segments = digitGlyph;
				ST_RUN: next_segments = (weakSignal && !flashOn) ? rsd_pkg::GLYPH_BLANK : digitGlyph;
				ST_ALIGN: next_segments = alignSegs;
				default: next_segments = rsd_pkg::GLYPH_BLANK;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			segments <= rsd_pkg::GLYPH_BLANK;
			alignView <= 1'b0;
		end else begin
			segments <= next_segments;
			alignView <= (state == ST_ALIGN) && !errActive;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	selftest_eight_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(state == ST_SELFTEST && !errActive) |=> segments == rsd_pkg::GLYPH_EIGHT)
		else $error("self-test glyph missing");
	steady_mode_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(state == ST_RUN && !errActive && !weakSignal) |=> segments == $past(digitGlyph))
		else $error("mode digit not steady");
	weak_blank_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(state == ST_RUN && !errActive && weakSignal && !flashOn) |=> segments == rsd_pkg::GLYPH_BLANK)
		else $error("weak signal not flashing");
	letter_class_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(errActive && !errShowCode && heldErr.errClass == rsd_pkg::CLASS_EXTERNAL) |=> segments == rsd_pkg::GLYPH_E)
		else $error("wrong error letter");
	err_cycle_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(errActive && errCnt == TW'(ERRPH_CYC - 1) && $past(errActive)) |=> errShowCode != $past(errShowCode))
		else $error("error phase did not alternate");
	block_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
		blockLatch |=> blockLatch)
		else $error("blocking error released");
	enter_align_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(state == ST_RUN && !aligned) |=> state == ST_ALIGN)
		else $error("alignment not entered");
	mixed_mid_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(state == ST_ALIGN && !errActive && mixed) |=> !segments[rsd_pkg::SEG_MID])
		else $error("middle segment used in mixed variant");
	zone_dark_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(state == ST_ALIGN && !errActive && beams.anyClear == 3'h0) |=> segments == rsd_pkg::GLYPH_BLANK)
		else $error("interrupted zone lit");
	leave_align_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(state == ST_ALIGN && !fieldFree) |=> state == ST_ALIGN)
		else $error("left alignment with field interrupted");
	err_first_a: assert property (@(posedge mclk) disable iff (!rst_b)
		errActive |=> !alignView)
		else $error("alignment shown over error");
	cov_align_c: cover property (@(posedge mclk) disable iff (!rst_b) state == ST_RUN ##1 state == ST_ALIGN);
	cov_back_c: cover property (@(posedge mclk) disable iff (!rst_b) state == ST_ALIGN ##1 state == ST_RUN);
	cov_err_c: cover property (@(posedge mclk) disable iff (!rst_b) errActive && errShowCode);
	cov_block_c: cover property (@(posedge mclk) disable iff (!rst_b) blockLatch);
endmodule : rsd_display
`default_nettype wire

// ===== rsd_pkg.sv
// Purpose: shared constants and types for the receiver status display
// Assumes: 100 MHz mclk
// Notes: segment order is {g,f,e,d,c,b,a}, a = top, g = middle, d = bottom
`default_nettype none
package rsd_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int FLASH_HZ = 2;
	localparam int FLASH_HALF_CYC = CLK_HZ / (2 * FLASH_HZ);
	localparam int SELFTEST_MS = 1000;
	localparam int SELFTEST_CYC = (CLK_HZ / 1000) * SELFTEST_MS;
	localparam int RESP_MS = 1000;
	localparam int RESP_CYC = (CLK_HZ / 1000) * RESP_MS;
	localparam int ERRPH_MS = 1000;
	localparam int ERRPH_CYC = (CLK_HZ / 1000) * ERRPH_MS;
	localparam int ALIGN_S = 5;
	localparam int ALIGN_CYC = CLK_HZ * ALIGN_S;
	localparam int SEG_TOP = 0;
	localparam int SEG_BOT = 3;
	localparam int SEG_MID = 6;
	localparam logic [6:0] GLYPH_EIGHT = 7'h7F;
	localparam logic [6:0] GLYPH_T = 7'h78;
	localparam logic [6:0] GLYPH_F = 7'h71;
	localparam logic [6:0] GLYPH_E = 7'h79;
	localparam logic [6:0] GLYPH_U = 7'h3E;
	localparam logic [6:0] GLYPH_BLANK = 7'h00;
	localparam logic [1:0] CLASS_INTERNAL = 2'h0;
	localparam logic [1:0] CLASS_EXTERNAL = 2'h1;
	localparam logic [1:0] CLASS_USAGE = 2'h2;

	typedef struct packed {
		logic pending;
		logic blocking;
		logic [1:0] errClass;
		logic [3:0] code;
	} rsd_err_t;

	typedef struct packed {
		logic [2:0] anyClear;
		logic [2:0] allClear;
	} rsd_beams_t;
endpackage : rsd_pkg
`default_nettype wire

// ===== rsd_digit.sv
// Purpose: hex digit to seven-segment glyph
// Assumes: segment order {g,f,e,d,c,b,a}, active high
// Notes: pure lookup, no state
`timescale 1ns/10ps
`default_nettype none
module rsd_digit (
	// value
	input wire logic [3:0] value,
	// glyph
	output logic [6:0] glyph
);
	always_comb begin
		case (value)
			4'h0: glyph = 7'h3F;
			4'h1: glyph = 7'h06;
			4'h2: glyph = 7'h5B;
			4'h3: glyph = 7'h4F;
			4'h4: glyph = 7'h66;
			4'h5: glyph = 7'h6D;
			4'h6: glyph = 7'h7D;
			4'h7: glyph = 7'h07;
			4'h8: glyph = 7'h7F;
			4'h9: glyph = 7'h6F;
			4'hA: glyph = 7'h77;
			4'hB: glyph = 7'h7C;
			4'hC: glyph = 7'h39;
			4'hD: glyph = 7'h5E;
			4'hE: glyph = 7'h79;
			default: glyph = 7'h71;
		endcase
	end
endmodule : rsd_digit
`default_nettype wire

// ===== rsd_viewer.sv
// Purpose: operator eye on the seven-segment glass
// Assumes: watch held high for the look window
// Notes: or/and of lit segments tell steady, flashing, dark
`timescale 1ns/10ps
`default_nettype none
module rsd_viewer (
	// clock
	input wire logic mclk,
	// look window and glass
	input wire logic watch,
	input wire logic [6:0] segments,
	// what the eye saw
	output logic [6:0] litAny,
	output logic [6:0] litAll
);
	// a human sees no single cycle, only what stays or blinks
	always_ff @(posedge mclk) begin
		if (!watch) begin
			litAny <= 7'h00;
			litAll <= 7'h7F;
		end else begin
			litAny <= litAny | segments;
			litAll <= litAll & segments;
		end
	end
endmodule : rsd_viewer
`default_nettype wire

// ===== rsd_display_tb.sv
// Purpose: self-checking bench for rsd_display
// Assumes: shortened counts, viewer model on the glass
// Notes: samples 1 ns after the edge so registered outputs have landed
`timescale 1ns/10ps
`default_nettype none
module rsd_display_tb;
	localparam int PH = 8;
	localparam int AL = 20;
	localparam logic [6:0] DIG [10] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07, 7'h7F, 7'h6F};
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] modeSel = 4'h1;
	logic mixedRes = 1'b0;
	logic [7:0] respTimeBcd = 8'h12;
	logic weakSignal = 1'b0;
	logic aligned = 1'b1;
	logic fieldFree = 1'b1;
	rsd_pkg::rsd_beams_t beams = 6'h3F;
	rsd_pkg::rsd_err_t err = 8'h00;
	logic [6:0] segments;
	logic alignView;
	logic watch = 1'b0;
	logic [6:0] litAny;
	logic [6:0] litAll;
	int errTotal = 0;
	int nTests = 0;
	always #5 mclk = ~mclk;
	rsd_display #(.SELFTEST_CYC(PH), .RESP_CYC(PH), .ERRPH_CYC(PH), .ALIGN_CYC(AL), .FLASH_HALF_CYC(3))
	rsd_display_inst (.mclk(mclk), .rst_b(rst_b), .modeSel(modeSel), .mixedRes(mixedRes),
		.respTimeBcd(respTimeBcd), .weakSignal(weakSignal), .aligned(aligned), .fieldFree(fieldFree),
		.beams(beams), .err(err), .segments(segments), .alignView(alignView));
	rsd_viewer rsd_viewer_inst (.mclk(mclk), .watch(watch), .segments(segments), .litAny(litAny), .litAll(litAll));
	// ****
	// helpers
	// ****
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : cyc
	task automatic chk(input string what, input logic [6:0] seen, input logic [6:0] exp);
		nTests++;
		if (seen !== exp) begin
			errTotal++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic look(input int n);
		@(posedge mclk);
		watch <= 1'b1;
		repeat (n) @(posedge mclk);
		watch <= 1'b0;
		#1;
	endtask : look
	task automatic giveVerdict();
		$display("checks %0d mismatches %0d", nTests, errTotal);
		if (errTotal == 0 && nTests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : giveVerdict
	// ****
	// scenarios
	// ****
	task automatic tPower(input logic [7:0] bcd);
		@(posedge mclk);
		rst_b <= 1'b0;
		respTimeBcd <= bcd;
		aligned <= 1'b1;
		repeat (4) @(posedge mclk);
		rst_b <= 1'b1;
		cyc(4);
		chk("selftest", segments, rsd_pkg::GLYPH_EIGHT);
		cyc(PH);
		chk("t", segments, rsd_pkg::GLYPH_T);
		cyc(PH);
		chk("tens", segments, DIG[bcd[7:4]]);
		cyc(PH);
		chk("units", segments, DIG[bcd[3:0]]);
		cyc(PH);
		chk("mode", segments, DIG[modeSel]);
	endtask : tPower
	task automatic tMode();
		logic [3:0] m [4] = '{4'h1, 4'h4, 4'h5, 4'h6};
		for (int i = 0; i < 4; i++) begin
			@(posedge mclk);
			modeSel <= m[i];
			cyc(5);
			look(12);
			chk("mode any", litAny, DIG[m[i]]);
			chk("mode all", litAll, DIG[m[i]]);
		end
		@(posedge mclk);
		weakSignal <= 1'b1;
		look(12);
		chk("weak any", litAny, DIG[6]);
		chk("weak all", litAll, 7'h00);
		@(posedge mclk);
		weakSignal <= 1'b0;
	endtask : tMode
	task automatic tAlign();
		@(posedge mclk);
		beams <= {3'b011, 3'b001};
		fieldFree <= 1'b0;
		cyc(AL / 2);
		chk("early", {6'h00, alignView}, 7'h00);
		cyc(AL);
		chk("entered", {6'h00, alignView}, 7'h01);
		look(12);
		chk("uni any", litAny, 7'h41);
		chk("uni all", litAll, 7'h01);
		@(posedge mclk);
		mixedRes <= 1'b1;
		beams <= {3'b111, 3'b111};
		cyc(4);
		look(12);
		chk("mixed any", litAny, 7'h09);
		chk("mixed all", litAll, 7'h09);
		@(posedge mclk);
		beams <= 6'h00;
		cyc(3);
		look(8);
		chk("dark any", litAny, 7'h00);
		@(posedge mclk);
		beams <= 6'h3F;
		@(posedge mclk);
		fieldFree <= 1'b1;
		cyc(AL / 2);
		chk("held", {6'h00, alignView}, 7'h01);
		cyc(AL);
		chk("left", {6'h00, alignView}, 7'h00);
		chk("mode back", segments, DIG[modeSel]);
		@(posedge mclk);
		aligned <= 1'b0;
		cyc(3);
		chk("unaligned", {6'h00, alignView}, 7'h01);
	endtask : tAlign
	task automatic tErr(input logic [1:0] cls, input logic [6:0] letter, input logic blk);
		int n;
		@(posedge mclk);
		err <= {1'b1, blk, cls, 4'h3};
		n = 0;
		cyc(1);
		while (segments !== letter && n < 20) begin
			cyc(1);
			n++;
		end
		chk("letter", segments, letter);
		chk("no align", {6'h00, alignView}, 7'h00);
		while (segments === letter && n < 40) begin
			cyc(1);
			n++;
		end
		chk("code", segments, DIG[3]);
		n = 0;
		while (segments === DIG[3] && n < 40) begin
			cyc(1);
			n++;
		end
		chk("code len", 7'(n), 7'(PH));
		chk("again", segments, letter);
		@(posedge mclk);
		err <= 8'h00;
		cyc(4);
		look(2 * PH + 2);
		chk("after clear", litAny, blk ? (letter | DIG[3]) : 7'h09);
	endtask : tErr
	initial begin
		tPower(8'h12);
		tMode();
		tAlign();
		tErr(rsd_pkg::CLASS_INTERNAL, rsd_pkg::GLYPH_F, 1'b0);
		tErr(rsd_pkg::CLASS_EXTERNAL, rsd_pkg::GLYPH_E, 1'b0);
		tErr(rsd_pkg::CLASS_USAGE, rsd_pkg::GLYPH_U, 1'b0);
		tErr(rsd_pkg::CLASS_INTERNAL, rsd_pkg::GLYPH_F, 1'b1);
		tPower(8'h07);
		giveVerdict();
	end
	// whole run is about 450 cycles
	initial begin
		repeat (5000) @(posedge mclk);
		errTotal++;
		giveVerdict();
	end
endmodule : rsd_display_tb
`default_nettype wire
